// ===== rtl/prot_supervisor_regs.vh
// Constants of the protection reaction supervisor: encodings and timing counts.
// Assumes a 20 MHz controller clock; times are given in microseconds.
`ifndef PROT_SUPERVISOR_REGS_VH
`define PROT_SUPERVISOR_REGS_VH

// ==========================================================================
// Clock and slot timing
// ==========================================================================
`define CLK_MHZ 20
`define SLOT_TIME_US 32
`define SLOT_CYCLES (`SLOT_TIME_US * `CLK_MHZ)
`define STAGE_OFF_SLOTS 4

// ==========================================================================
// Reaction encodings
// ==========================================================================
`define REACT_AUTO 2'h0
`define REACT_FAST 2'h1
`define REACT_LATCH 2'h2
`define REACT_STOP 2'h3

// ==========================================================================
// Protection sources, one bit each
// ==========================================================================
`define NUM_PROT 8
`define PROT_VCC_OV 0
`define PROT_WATCHDOG 1
`define PROT_PARITY 2
`define PROT_CLOCK 3
`define PROT_CRC 4
`define PROT_TASK 5
`define PROT_STAGE1 6
`define PROT_STAGE2 7

// ==========================================================================
// Default counts, in slots, and the no-error code
// ==========================================================================
`define DEF_RESTART_SLOTS 16'h7A12
`define DEF_FAST_RESTART_SLOTS 16'h0C35
`define DEF_SELF_SUPPLY_SLOTS 16'h186A
`define DEF_WATCHDOG_SLOTS 16'h0020
`define ERR_NONE 4'h0

`endif

// ===== rtl/slot_tick.v
// Slot divider: one-cycle pulse every slot of the controller clock.
// Assumes the synchronous reset of the host clock domain.
`timescale 1ns/100ps
`include "prot_supervisor_regs.vh"

module slot_tick #(
	parameter integer DIV = `SLOT_CYCLES
) (
	input wire clk_i,
	input wire srst_i,
	output reg tick_o
);

	reg [15:0] cnt_q;

	always @(posedge clk_i) begin
		if (srst_i) begin
			cnt_q <= 16'h0000;
			tick_o <= 1'b0;
		end else if (cnt_q == DIV[15:0] - 16'h0001) begin
			cnt_q <= 16'h0000;
			tick_o <= 1'b1;
		end else begin
			cnt_q <= cnt_q + 16'h0001;
			tick_o <= 1'b0;
		end
	end

endmodule // slot_tick

// ===== rtl/blank_filter.v
// Blanking filter: raises its trigger once the condition has held without a break
// for more than the blanking count of slots. Condition is a same-clock level.
`timescale 1ns/100ps
`include "prot_supervisor_regs.vh"

module blank_filter (
	input wire clk_i,
	input wire srst_i,
	input wire slot_i,
	input wire cond_i,
	input wire [15:0] blank_i,
	output reg trig_o
);

	reg [15:0] cnt_q;

	always @(posedge clk_i) begin
		if (srst_i || !cond_i) begin
			cnt_q <= 16'h0000;
			trig_o <= 1'b0;
		end else if (slot_i) begin
			if (cnt_q > blank_i) begin
				trig_o <= 1'b1;
			end else begin
				cnt_q <= cnt_q + 16'h0001;
			end
		end
	end

endmodule // blank_filter

// ===== rtl/protection_reaction_supervisor.v
// Protection reaction supervisor: lockout, integrity checks, reactions, restart.
// Assumes comparator and check inputs arrive from pins and are synchronised here;
// firmware strobes and configuration come from logic on the same clock.
`timescale 1ns/100ps
`include "prot_supervisor_regs.vh"

module protection_reaction_supervisor #(
	parameter integer NP = `NUM_PROT,
	parameter integer SLOT_DIV = `SLOT_CYCLES
) (
	input wire clk_i,
	input wire srst_i,
	input wire above_enable_i,
	input wire below_disable_i,
	input wire above_ov_i,
	input wire below_lockout_low_i,
	input wire above_lockout_high_i,
	input wire self_supply_ok_i,
	input wire parity_err_i,
	input wire clock_fail_i,
	input wire stage1_fault_i,
	input wire stage2_fault_i,
	input wire wd_service_i,
	input wire crc_done_i,
	input wire crc_ok_i,
	input wire task_fail_i,
	input wire stage1_ss_done_i,
	input wire stage2_start_ok_i,
	input wire err_read_i,
	input wire [2*NP-1:0] reaction_cfg_i,
	input wire [16*NP-1:0] blank_cfg_i,
	input wire [15:0] restart_slots_i,
	input wire [15:0] fast_restart_slots_i,
	input wire [15:0] self_supply_slots_i,
	input wire [15:0] watchdog_slots_i,
	output reg chip_enable_o,
	output reg normal_op_o,
	output reg stage1_gate_en_o,
	output reg stage2_gate_en_o,
	output reg startup_cell_on_o,
	output reg param_mode_o,
	output reg latched_o,
	output reg [3:0] error_code_o
);

	// ==========================================================================
	// States
	// ==========================================================================
	localparam [7:0] S_OFF = 8'h01;
	localparam [7:0] S_CHECK = 8'h02;
	localparam [7:0] S_START1 = 8'h04;
	localparam [7:0] S_START2 = 8'h08;
	localparam [7:0] S_RUN = 8'h10;
	localparam [7:0] S_SHUT = 8'h20;
	localparam [7:0] S_WAIT = 8'h40;
	localparam [7:0] S_HALT = 8'h80;

	// ==========================================================================
	// Input synchronisers
	// ==========================================================================
	localparam integer NS = 10;
	wire [NS-1:0] raw_w = {stage2_fault_i, stage1_fault_i, clock_fail_i, parity_err_i,
		self_supply_ok_i, above_lockout_high_i, below_lockout_low_i, above_ov_i,
		below_disable_i, above_enable_i};
	reg [NS-1:0] meta_q;
	reg [NS-1:0] sync_q;

	always @(posedge clk_i) begin
		if (srst_i) begin
			meta_q <= {NS{1'b0}};
			sync_q <= {NS{1'b0}};
		end else begin
			meta_q <= raw_w;
			sync_q <= meta_q;
		end
	end

	wire on_w = sync_q[0];
	wire off_w = sync_q[1];
	wire ov_w = sync_q[2];
	wire low_w = sync_q[3];
	wire high_w = sync_q[4];
	wire ssok_w = sync_q[5];

	// ==========================================================================
	// Slot tick and per-protection blanking
	// ==========================================================================
	wire slot_w;

	slot_tick #(.DIV(SLOT_DIV)) u_tick (
		.clk_i(clk_i),
		.srst_i(srst_i),
		.tick_o(slot_w)
	);

	reg [15:0] wd_cnt_q;
	reg crc_bad_q;
	reg [7:0] state_q;
	wire [NP-1:0] cond_w;
	wire [NP-1:0] trig_w;

	assign cond_w[`PROT_VCC_OV] = ov_w;
	assign cond_w[`PROT_WATCHDOG] = (wd_cnt_q >= watchdog_slots_i);
	assign cond_w[`PROT_PARITY] = sync_q[6];
	assign cond_w[`PROT_CLOCK] = sync_q[7];
	assign cond_w[`PROT_CRC] = crc_bad_q;
	assign cond_w[`PROT_TASK] = task_fail_i;
	assign cond_w[`PROT_STAGE1] = sync_q[8];
	assign cond_w[`PROT_STAGE2] = sync_q[9];

	genvar g;
	generate
		for (g = 0; g < NP; g = g + 1) begin : g_blank
			blank_filter u_blank (
				.clk_i(clk_i),
				.srst_i(srst_i),
				.slot_i(slot_w),
				.cond_i(cond_w[g]),
				.blank_i(blank_cfg_i[16*g +: 16]),
				.trig_o(trig_w[g])
			);
		end
	endgenerate

	// Watchdog runs only while firmware is alive, i.e. outside lockout.
	always @(posedge clk_i) begin
		if (srst_i || wd_service_i || state_q == S_OFF) begin
			wd_cnt_q <= 16'h0000;
		end else if (slot_w && wd_cnt_q != 16'hFFFF) begin
			wd_cnt_q <= wd_cnt_q + 16'h0001;
		end
	end

	// Returns the lowest triggered protection index plus one, zero if none.
	function [3:0] first_code;
		input [NP-1:0] t;
		integer i;
		begin
			first_code = `ERR_NONE;
			for (i = NP - 1; i >= 0; i = i - 1) begin
				if (t[i]) begin
					first_code = i[3:0] + 4'h1;
				end
			end
		end
	endfunction

	// ==========================================================================
	// Reaction state machine
	// ==========================================================================
	wire any_trig_w = |trig_w;
	wire [3:0] code_w = first_code(trig_w);
	reg [1:0] react_q;
	reg [15:0] cnt_q;
	reg [2:0] slots_q;
	reg related2_q;
	reg ss_to_q;

	always @(posedge clk_i) begin
		if (srst_i) begin
			state_q <= S_OFF;
			react_q <= `REACT_AUTO;
			cnt_q <= 16'h0000;
			slots_q <= 3'h0;
			related2_q <= 1'b0;
			ss_to_q <= 1'b0;
			crc_bad_q <= 1'b0;
			chip_enable_o <= 1'b0;
			normal_op_o <= 1'b0;
			stage1_gate_en_o <= 1'b0;
			stage2_gate_en_o <= 1'b0;
			param_mode_o <= 1'b0;
			latched_o <= 1'b0;
			error_code_o <= `ERR_NONE;
		end else begin
			if (crc_done_i) begin
				crc_bad_q <= !crc_ok_i;
			end
			if (err_read_i && error_code_o != `ERR_NONE) begin
				error_code_o <= `ERR_NONE;
			end
			case (state_q)
			S_OFF: begin
				chip_enable_o <= 1'b0;
				param_mode_o <= 1'b0;
				latched_o <= 1'b0;
				crc_bad_q <= 1'b0;
				if (on_w) begin
					chip_enable_o <= 1'b1;
					state_q <= S_CHECK;
					cnt_q <= 16'h0000;
				end
			end
			S_CHECK: begin
				if (!any_trig_w && !(|cond_w)) begin
					normal_op_o <= 1'b1;
					stage1_gate_en_o <= 1'b1;
					cnt_q <= 16'h0000;
					ss_to_q <= 1'b0;
					state_q <= S_START1;
				end
			end
			S_START1: begin
				if (stage1_ss_done_i) begin
					state_q <= S_START2;
				end
			end
			S_START2: begin
				if (stage2_start_ok_i) begin
					stage2_gate_en_o <= 1'b1;
					state_q <= S_RUN;
				end
			end
			default: begin
			end
			endcase
			// Self-supply timeout counts from enable until the auxiliary supply holds.
			if ((state_q == S_START1 || state_q == S_START2 || state_q == S_RUN)
				&& !ssok_w && !ss_to_q) begin
				if (slot_w) begin
					cnt_q <= cnt_q + 16'h0001;
				end
				if (cnt_q >= self_supply_slots_i || off_w) begin
					ss_to_q <= 1'b1;
					react_q <= `REACT_FAST;
					related2_q <= 1'b0;
					slots_q <= 3'h0;
					normal_op_o <= 1'b0;
					state_q <= S_SHUT;
				end
			end else if ((state_q == S_START1 || state_q == S_START2 || state_q == S_RUN)
				&& any_trig_w) begin
				if (trig_w[`PROT_VCC_OV]) begin
					react_q <= `REACT_STOP;
				end else begin
					react_q <= reaction_cfg_i[2*(code_w-4'h1) +: 2];
				end
				if (error_code_o == `ERR_NONE) begin
					error_code_o <= code_w;
				end
				related2_q <= trig_w[`PROT_STAGE2] && !trig_w[`PROT_STAGE1];
				slots_q <= 3'h0;
				normal_op_o <= 1'b0;
				state_q <= S_SHUT;
			end
			if (state_q == S_SHUT) begin
				if (related2_q) begin
					stage2_gate_en_o <= 1'b0;
				end else begin
					stage1_gate_en_o <= 1'b0;
				end
				if (slot_w) begin
					slots_q <= slots_q + 3'h1;
				end
				if (slot_w && slots_q == 3'h0) begin
					stage1_gate_en_o <= 1'b0;
					stage2_gate_en_o <= 1'b0;
					cnt_q <= 16'h0000;
					case (react_q)
					`REACT_LATCH: begin
						latched_o <= 1'b1;
						state_q <= S_HALT;
					end
					`REACT_STOP: begin
						param_mode_o <= 1'b1;
						state_q <= S_HALT;
					end
					default: begin
						state_q <= S_WAIT;
					end
					endcase
				end
			end
			if (state_q == S_WAIT) begin
				if (slot_w) begin
					cnt_q <= cnt_q + 16'h0001;
				end
				if ((react_q == `REACT_FAST && cnt_q >= fast_restart_slots_i)
					|| (react_q == `REACT_AUTO && cnt_q >= restart_slots_i)) begin
					error_code_o <= `ERR_NONE;
					state_q <= S_CHECK;
				end
			end
			// Losing the supply always ends in lockout; stop leaves only this way, latch also leaves on off_w.
			if (state_q != S_OFF && low_w) begin
				state_q <= S_OFF;
				chip_enable_o <= 1'b0;
				normal_op_o <= 1'b0;
				stage1_gate_en_o <= 1'b0;
				stage2_gate_en_o <= 1'b0;
				error_code_o <= `ERR_NONE;
			end else if (state_q != S_OFF && state_q != S_SHUT && off_w
				&& !(state_q == S_HALT && react_q == `REACT_STOP)) begin
				// In stop the outside equipment is expected to hold the supply.
				state_q <= S_OFF;
				chip_enable_o <= 1'b0;
				normal_op_o <= 1'b0;
				stage1_gate_en_o <= 1'b0;
				stage2_gate_en_o <= 1'b0;
			end
		end
	end

	// ==========================================================================
	// Startup cell hysteresis in restart wait and in latch
	// ==========================================================================
	always @(posedge clk_i) begin
		if (srst_i) begin
			startup_cell_on_o <= 1'b1;
		end else if (state_q == S_OFF || state_q == S_CHECK) begin
			startup_cell_on_o <= 1'b1;
		end else if (state_q == S_WAIT || (state_q == S_HALT && react_q == `REACT_LATCH)) begin
			if (low_w) begin
				startup_cell_on_o <= 1'b1;
			end else if (high_w) begin
				startup_cell_on_o <= 1'b0;
			end
		end else begin
			startup_cell_on_o <= 1'b0;
		end
	end

endmodule // protection_reaction_supervisor

// ===== tb/prot_checker_assertions.sv
// Checker: stage order, reaction timing and error code hold at the supervisor ports.
// Assumes binding to the supervisor; slot length comes from SLOT_DIV.
`timescale 1ns/100ps
module prot_checker #(
	parameter integer NP = 8,
	parameter integer SLOT_DIV = 640
) (
	input wire clk_i,
	input wire srst_i,
	input wire stage1_ss_done_i,
	input wire stage2_start_ok_i,
	input wire chip_enable_o,
	input wire normal_op_o,
	input wire stage1_gate_en_o,
	input wire stage2_gate_en_o,
	input wire param_mode_o,
	input wire latched_o,
	input wire [3:0] error_code_o
);
	localparam int T1 = 4 * SLOT_DIV;
	localparam int T2 = 8 * SLOT_DIV + 8;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (srst_i);
	sequence new_code;
		error_code_o == 4'h0 ##1 error_code_o != 4'h0;
	endsequence
	a_gate_needs_chip: assert property ((stage1_gate_en_o || stage2_gate_en_o) |-> chip_enable_o)
		else $error("gate on while chip off");
	a_related_off: assert property (new_code |-> ##[0:T1] (error_code_o == 4'h7 ?
		!stage1_gate_en_o : (error_code_o == 4'h8 ? !stage2_gate_en_o : 1'b1)))
		else $error("related stage late");
	a_all_off: assert property (new_code |-> ##[0:T2] !(stage1_gate_en_o || stage2_gate_en_o))
		else $error("stages late");
	a_ov_stop: assert property (error_code_o == 4'h0 ##1 error_code_o == 4'h1 |-> ##[0:T2] param_mode_o)
		else $error("no stop on overvoltage");
	a_code_kept: assert property (error_code_o != 4'h0 |=> error_code_o == 4'h0 || $stable(error_code_o))
		else $error("code replaced");
	a_stage_order: assert property ($rose(stage2_gate_en_o) |-> stage1_gate_en_o && stage1_ss_done_i)
		else $error("stage 2 early");
	a_start_cond: assert property ($rose(stage2_gate_en_o) |-> stage2_start_ok_i)
		else $error("stage 2 without condition");
	a_latch_halt: assert property (latched_o |-> !(stage1_gate_en_o || stage2_gate_en_o || normal_op_o))
		else $error("switching in latch");
	a_stop_halt: assert property (param_mode_o |-> !(stage1_gate_en_o || stage2_gate_en_o || latched_o))
		else $error("switching in stop");
	c_latch: cover property ($rose(latched_o));
	c_stop: cover property ($rose(param_mode_o));
	c_run: cover property ($rose(stage2_gate_en_o));
endmodule // prot_checker

bind protection_reaction_supervisor prot_checker #(.NP(NP), .SLOT_DIV(SLOT_DIV)) chk (
	.clk_i(clk_i), .srst_i(srst_i), .stage1_ss_done_i(stage1_ss_done_i),
	.stage2_start_ok_i(stage2_start_ok_i), .chip_enable_o(chip_enable_o),
	.normal_op_o(normal_op_o), .stage1_gate_en_o(stage1_gate_en_o),
	.stage2_gate_en_o(stage2_gate_en_o), .param_mode_o(param_mode_o),
	.latched_o(latched_o), .error_code_o(error_code_o));

// ===== tb/stage_partner.sv
// Model of the power stage drivers and auxiliary winding beyond the supervisor.
// Assumes the supervisor clock; soft start lasts DLY cycles.
`timescale 1ns/100ps
module stage_partner #(
	parameter integer DLY = 6
) (
	input wire clk_i,
	input wire stage1_en_i,
	input wire aux_fail_i,
	output wire ss_done_o,
	output wire start_ok_o,
	output wire self_ok_o
);
	reg [7:0] run_q = 8'h00;
	always @(posedge clk_i) begin
		if (!stage1_en_i)
			run_q <= 8'h00;
		else if (run_q != 8'hFF)
			run_q <= run_q + 8'h01;
	end
	// Soft start ends first; the second stage condition follows later.
	assign ss_done_o = run_q >= DLY;
	assign start_ok_o = run_q >= 2 * DLY;
	// The winding supplies the chip once the first stage soft start ends.
	assign self_ok_o = !aux_fail_i && run_q >= DLY;
endmodule // stage_partner

// ===== tb/tb_top.sv
// Testbench: start, trips with every reaction, latch, stop and self supply loss.
// Assumes a short slot divider so every count stays small.
`timescale 1ns/100ps
`include "prot_supervisor_regs.vh"
module tb_top;
	localparam integer SD = 4;
	reg clk_i = 1'b0;
	reg srst_i = 1'b1;
	reg above_enable_i = 1'b0, above_ov_i = 1'b0, below_lockout_low_i = 1'b0, below_disable_i = 1'b0;
	reg above_lockout_high_i = 1'b0, parity_err_i = 1'b0, clock_fail_i = 1'b0;
	reg stage1_fault_i = 1'b0, stage2_fault_i = 1'b0, wd_service_i = 1'b0, wd_on = 1'b1;
	reg crc_done_i = 1'b0, crc_ok_i = 1'b1, task_fail_i = 1'b0, err_read_i = 1'b0, aux = 1'b0;
	reg [15:0] reaction_cfg_i = 16'h0000;
	reg [127:0] blank_cfg_i = {8{16'h0002}};
	wire chip_enable_o, normal_op_o, stage1_gate_en_o, stage2_gate_en_o;
	wire startup_cell_on_o, param_mode_o, latched_o, ss_done, start_ok, self_ok;
	wire [3:0] error_code_o;
	integer mismatches = 0, checks = 0, t, i;
	always #25 clk_i = ~clk_i;
	always @(posedge clk_i) wd_service_i <= wd_on & !wd_service_i;
	protection_reaction_supervisor #(.SLOT_DIV(SD)) DUT (
		.clk_i(clk_i), .srst_i(srst_i), .above_enable_i(above_enable_i),
		.below_disable_i(below_disable_i), .above_ov_i(above_ov_i),
		.below_lockout_low_i(below_lockout_low_i), .above_lockout_high_i(above_lockout_high_i),
		.self_supply_ok_i(self_ok), .parity_err_i(parity_err_i), .clock_fail_i(clock_fail_i),
		.stage1_fault_i(stage1_fault_i), .stage2_fault_i(stage2_fault_i),
		.wd_service_i(wd_service_i), .crc_done_i(crc_done_i), .crc_ok_i(crc_ok_i),
		.task_fail_i(task_fail_i), .stage1_ss_done_i(ss_done), .stage2_start_ok_i(start_ok),
		.err_read_i(err_read_i), .reaction_cfg_i(reaction_cfg_i), .blank_cfg_i(blank_cfg_i),
		.restart_slots_i(16'h0018), .fast_restart_slots_i(16'h0005),
		.self_supply_slots_i(16'h001E), .watchdog_slots_i(16'h0008),
		.chip_enable_o(chip_enable_o), .normal_op_o(normal_op_o),
		.stage1_gate_en_o(stage1_gate_en_o), .stage2_gate_en_o(stage2_gate_en_o),
		.startup_cell_on_o(startup_cell_on_o), .param_mode_o(param_mode_o),
		.latched_o(latched_o), .error_code_o(error_code_o));
	stage_partner far (.clk_i(clk_i), .stage1_en_i(stage1_gate_en_o), .aux_fail_i(aux),
		.ss_done_o(ss_done), .start_ok_o(start_ok), .self_ok_o(self_ok));
	task report_and_stop;
		begin
			if (mismatches == 0 && checks > 0)
				$display("Run complete: PASS");
			else
				$display("Run complete: FAIL");
			$finish;
		end
	endtask
	task check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		begin
			checks = checks + 1;
			if (seen !== exp) begin
				mismatches = mismatches + 1;
				$display("mismatch %s expected %h seen %h", nm, exp, seen);
			end
		end
	endtask
	task tmo(input integer n, input integer lim);
		if (n >= lim) begin
			check("wait", n, 0);
			report_and_stop;
		end
	endtask
	task set_fault(input integer idx, input logic v);
		case (idx)
			0: above_ov_i <= v;
			1: wd_on <= !v;
			2: parity_err_i <= v;
			3: clock_fail_i <= v;
			4: begin
				crc_done_i <= 1'b1;
				crc_ok_i <= !v;
			end
			5: task_fail_i <= v;
			6: stage1_fault_i <= v;
			default: stage2_fault_i <= v;
		endcase
	endtask
	task wait_run;
		begin
			for (t = 0; t < 900 && stage2_gate_en_o !== 1'b1; t = t + 1) @(posedge clk_i);
			tmo(t, 900);
			check("run", {chip_enable_o, normal_op_o, stage1_gate_en_o}, 3'h7);
		end
	endtask
	task trip(input integer idx, input logic [1:0] rc);
		begin
			@(posedge clk_i);
			err_read_i <= 1'b1;
			reaction_cfg_i[2*idx +: 2] <= rc;
			blank_cfg_i[16*idx +: 16] <= idx + 1;
			@(posedge clk_i);
			err_read_i <= 1'b0;
			set_fault(idx, 1'b1);
			@(posedge clk_i);
			crc_done_i <= 1'b0;
			for (t = 0; t < 900 && error_code_o === 4'h0; t = t + 1) @(posedge clk_i);
			tmo(t, 900);
			check("code", error_code_o, idx + 1);
			if (idx != 1)
				check("blank", t >= (idx + 1) * SD && t <= (idx + 3) * SD + 6, 1'b1);
			set_fault(idx, 1'b0);
			@(posedge clk_i);
			crc_done_i <= 1'b0;
			repeat (SD + 2) @(posedge clk_i);
			check("gates", {stage1_gate_en_o, stage2_gate_en_o}, 2'b00);
		end
	endtask
	task power_cycle;
		begin
			@(posedge clk_i);
			below_lockout_low_i <= 1'b1;
			repeat (10) @(posedge clk_i);
			check("off", {chip_enable_o, latched_o, param_mode_o, error_code_o}, 7'h00);
			below_lockout_low_i <= 1'b0;
			wait_run;
		end
	endtask
	task start_blocked;
		begin
			parity_err_i <= 1'b1;
			above_enable_i <= 1'b1;
			repeat (50) @(posedge clk_i);
			check("blocked", {chip_enable_o, normal_op_o}, 2'b10);
			parity_err_i <= 1'b0;
			wait_run;
		end
	endtask
	task restart_scn;
		for (i = 1; i < 8; i = i + 1) begin
			trip(i, i[0] ? `REACT_FAST : `REACT_AUTO);
			for (t = 0; t < 900 && normal_op_o !== 1'b1; t = t + 1) @(posedge clk_i);
			tmo(t, 900);
			check("restart", i[0] ? t < 30 : t >= 30, 1'b1);
			wait_run;
		end
	endtask
	task latch_scn;
		begin
			trip(3, `REACT_LATCH);
			above_lockout_high_i <= 1'b1;
			repeat (200) @(posedge clk_i);
			check("latch", {latched_o, normal_op_o, startup_cell_on_o}, 3'h4);
			above_lockout_high_i <= 1'b0;
			power_cycle;
		end
	endtask
	task stop_scn;
		begin
			trip(0, `REACT_AUTO);
			check("stop", {param_mode_o, error_code_o}, 5'h11);
			stage1_fault_i <= 1'b1;
			repeat (40) @(posedge clk_i);
			check("first", error_code_o, 4'h1);
			stage1_fault_i <= 1'b0;
			below_disable_i <= 1'b1;
			repeat (10) @(posedge clk_i);
			check("hold", {param_mode_o, error_code_o}, 5'h11);
			below_disable_i <= 1'b0;
			err_read_i <= 1'b1;
			@(posedge clk_i);
			err_read_i <= 1'b0;
			repeat (4) @(posedge clk_i);
			check("read", error_code_o, 4'h0);
			power_cycle;
		end
	endtask
	task aux_scn;
		begin
			aux <= 1'b1;
			power_cycle;
			for (t = 0; t < 400 && normal_op_o !== 1'b0; t = t + 1) @(posedge clk_i);
			tmo(t, 400);
			repeat (SD + 2) @(posedge clk_i);
			check("aux", {stage1_gate_en_o, latched_o, param_mode_o}, 3'h0);
			aux <= 1'b0;
			for (t = 0; t < 900 && normal_op_o !== 1'b1; t = t + 1) @(posedge clk_i);
			check("fast", t < 60, 1'b1);
			wait_run;
		end
	endtask
	initial begin
		repeat (20) @(posedge clk_i);
		srst_i <= 1'b0;
		start_blocked;
		restart_scn;
		latch_scn;
		stop_scn;
		aux_scn;
		report_and_stop;
	end
endmodule // tb_top
